// file: icto_pkg.sv
// constants and types of the infrared carrier timer output stage
// assumes a single 25 MHz clock standing in for the core's oscillator
`default_nettype none
package icto_pkg;
    // clock rates; the oscillator is modelled by fractional ticks
    localparam logic [31:0] CLK_HZ      = 32'd25_000_000;
    localparam logic [31:0] OSC_HZ      = 32'd4_000_000;
    localparam logic [31:0] CARRIER_MUL = 32'd2;
    localparam logic [31:0] TICK_INC    = OSC_HZ * CARRIER_MUL;
    // timer step of 64 oscillator periods, in doubled-clock ticks
    localparam int          STEP_OSC    = 64;
    localparam logic [6:0]  STEP_LAST   = 7'(STEP_OSC * 2 - 1);
    // field positions
    localparam int          ENA_BIT     = 9;
    localparam int          DIS_BIT     = 9;
    // reset values
    localparam logic [8:0]  RST_COUNT   = 9'h000;
    localparam logic        RST_ENA     = 1'b0;
    localparam logic [8:0]  RST_LOW     = 9'h001;
    localparam logic [9:0]  RST_HIGH    = 10'h201;

    typedef enum logic [1:0] {SEL_TMR, SEL_LOW, SEL_HIGH} icto_sel_t;
    typedef enum logic [1:0] {PH_IDLE, PH_LOW, PH_HIGH} icto_phase_t;

    // replace one nibble of the low byte of a 10-bit word
    function automatic logic [9:0] nib_merge(input logic [9:0] old,
                                             input logic       idx,
                                             input logic [3:0] nib);
        logic [9:0] r;
        r = old;
        if (idx) begin
            r[7:4] = nib;
        end else begin
            r[3:0] = nib;
        end
        return r;
    endfunction : nib_merge
endpackage : icto_pkg
`default_nettype wire

// file: icto_carrier.sv
// carrier phase generator: alternating low and high phases
// assumes tick is a one-cycle pulse at twice the oscillator rate
`default_nettype none
module icto_carrier (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       tick,
    input  wire logic       restart,
    input  wire logic       run_req,
    input  wire logic [8:0] low_period,
    input  wire logic [8:0] high_period,
    output logic            phase_high,
    output logic            active
);
    import icto_pkg::*;

    icto_phase_t phase_reg;
    logic [8:0]  cnt_reg;

    // each phase lasts period+1 ticks, then flips to the other register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_reg <= PH_IDLE;
            cnt_reg   <= 9'h000;
        end else if (restart) begin
            phase_reg <= PH_LOW;
            cnt_reg   <= 9'h000;
        end else begin
            case (phase_reg)
                PH_IDLE: begin
                    cnt_reg <= 9'h000;
                    if (run_req) begin
                        phase_reg <= PH_LOW;
                    end
                end
                PH_LOW: begin
                    if (!run_req) begin
                        phase_reg <= PH_IDLE;
                    end else if (tick && cnt_reg == low_period) begin
                        phase_reg <= PH_HIGH;
                        cnt_reg   <= 9'h000;
                    end else if (tick) begin
                        cnt_reg <= cnt_reg + 9'h001;
                    end
                end
                PH_HIGH: begin
                    // a high phase runs to its end unless restart comes first
                    if (tick && cnt_reg == high_period) begin
                        phase_reg <= run_req ? PH_LOW : PH_IDLE;
                        cnt_reg   <= 9'h000;
                    end else if (tick) begin
                        cnt_reg <= cnt_reg + 9'h001;
                    end
                end
                default: begin
                    phase_reg <= PH_IDLE;
                    cnt_reg   <= 9'h000;
                end
            endcase
        end
    end

    assign phase_high = (phase_reg == PH_HIGH);
    assign active     = (phase_reg != PH_IDLE);

    property p_low_stops;
        @(posedge clk) disable iff (!rst_b)
        (phase_reg == PH_LOW && !run_req && !restart)
            |=> phase_reg == PH_IDLE;
    endproperty
    a_low_stops: assert property (p_low_stops)
        else $error("low phase did not stop at once");

    property p_high_holds;
        @(posedge clk) disable iff (!rst_b)
        (phase_reg == PH_HIGH && !tick && !restart)
            |=> phase_reg == PH_HIGH;
    endproperty
    a_high_holds: assert property (p_high_holds)
        else $error("high phase cut short");

    property p_phase_len;
        @(posedge clk) disable iff (!rst_b)
        (phase_reg == PH_LOW && tick && cnt_reg == low_period
         && run_req && !restart) |=> phase_reg == PH_HIGH;
    endproperty
    a_phase_len: assert property (p_phase_len)
        else $error("low phase did not end after period+1 ticks");
endmodule : icto_carrier
`default_nettype wire

// file: icto_top.sv
// infrared carrier timer output stage: pattern timer, carrier, pins
// assumes the core drives one write or read strobe per cycle
//
// Overview of operation
// - nonzero load starts timer; zero stops it
// - counter decrements every 64 oscillator periods
// - enable flag shows timer state on pins
// - indicator low running; infrared high/carrier running
// - carrier may appear while timer runs
// - one 9-bit counter, two period registers
// - low-period bit 9 always reads zero
// - carrier counter ticks at twice oscillator
// - each phase lasts period plus one ticks
// - high-period bit 9 clear enables carrier
// - carrier starts with low phase on load
// - zero during low phase stops output immediately
// - zero during high phase finishes high first while enable flag stays set
// - infrared pin per enable, count, disable bit
// - periods readable, writable by nibble or whole
// - pins registered, one clock behind internal state
`default_nettype none
module icto_top (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire icto_pkg::icto_sel_t  wr_sel,
    input  wire logic                 wr_full,
    input  wire logic                 wr_nib,
    input  wire logic                 nib_idx,
    input  wire logic [3:0]           nib_data,
    input  wire logic [9:0]           wr_data,
    input  wire icto_pkg::icto_sel_t  rd_sel,
    output logic [9:0]                rd_data,
    output logic                      timer_zero,
    output logic                      infrared_output_pin,
    output logic                      transmit_indicator_pin,
    output logic                      transmit_indicator_oe
);
    import icto_pkg::*;

    logic [8:0]  count_reg;
    logic        timer_output_enable_flag;
    logic [8:0]  carrier_low_period;
    logic [9:0]  carrier_high_period;
    logic [31:0] acc_reg;
    logic [31:0] acc_sum;
    logic        tick_reg;
    logic [6:0]  div_reg;
    logic        step;
    logic        wr_any;
    logic [9:0]  tmr_word;
    logic [9:0]  tmr_next;
    logic        load;
    logic        running;
    logic        carrier_disable_bit;
    logic        ph_high;
    logic        ph_active;
    logic        ir_next;
    logic        led_next;
    logic [9:0]  low_merge;

    // fractional divider: average tick rate is exactly 2x oscillator
    assign acc_sum = acc_reg + TICK_INC;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_reg  <= 32'h0000_0000;
            tick_reg <= 1'b0;
        end else if (acc_sum >= CLK_HZ) begin
            acc_reg  <= acc_sum - CLK_HZ;
            tick_reg <= 1'b1;
        end else begin
            acc_reg  <= acc_sum;
            tick_reg <= 1'b0;
        end
    end

    // timer prescaler restarts on load so the first step is whole
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_reg <= 7'h00;
        end else if (load) begin
            div_reg <= 7'h00;
        end else if (tick_reg) begin
            div_reg <= (div_reg == STEP_LAST) ? 7'h00 : div_reg + 7'h01;
        end
    end
    assign step = tick_reg && (div_reg == STEP_LAST);

    // register writes: whole word or one nibble of the low byte
    assign wr_any   = wr_full || wr_nib;
    assign tmr_word = {timer_output_enable_flag, count_reg};
    always_comb begin
        tmr_next = wr_full ? wr_data : nib_merge(tmr_word, nib_idx, nib_data);
    end
    assign load = wr_any && (wr_sel == SEL_TMR) && (tmr_next[8:0] != 9'h000);

    // pattern timer down counter and output enable flag
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg                <= RST_COUNT;
            timer_output_enable_flag <= RST_ENA;
        end else if (wr_any && wr_sel == SEL_TMR) begin
            count_reg                <= tmr_next[8:0];
            timer_output_enable_flag <= tmr_next[ENA_BIT];
        end else if (step && count_reg != 9'h000) begin
            count_reg <= count_reg - 9'h001;
        end
    end
    assign running    = (count_reg != 9'h000);
    assign timer_zero = !running;

    // nibble write into the low period; bit 9 is dropped on purpose
    assign low_merge = nib_merge({1'b0, carrier_low_period},
                                 nib_idx, nib_data);

    // period registers; low bit 9 is not stored at all
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            carrier_low_period  <= RST_LOW;
            carrier_high_period <= RST_HIGH;
        end else if (wr_any && wr_sel == SEL_LOW) begin
            carrier_low_period <= wr_full ? wr_data[8:0]
                                          : low_merge[8:0];
        end else if (wr_any && wr_sel == SEL_HIGH) begin
            carrier_high_period <= wr_full ? wr_data
                : nib_merge(carrier_high_period, nib_idx, nib_data);
        end
    end
    assign carrier_disable_bit = carrier_high_period[DIS_BIT];

    // read port: data come from a register, one cycle after select
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= 10'h000;
        end else begin
            case (rd_sel)
                SEL_TMR:  rd_data <= tmr_word;
                SEL_LOW:  rd_data <= {1'b0, carrier_low_period};
                SEL_HIGH: rd_data <= carrier_high_period;
                default:  rd_data <= 10'h000;
            endcase
        end
    end

    // carrier is requested only while enabled, counting and not disabled
    icto_carrier u_carrier (
        .clk         (clk),
        .rst_b       (rst_b),
        .tick        (tick_reg),
        .restart     (load && !carrier_disable_bit),
        .run_req     (running && timer_output_enable_flag
                      && !carrier_disable_bit),
        .low_period  (carrier_low_period),
        .high_period (carrier_high_period[8:0]),
        .phase_high  (ph_high),
        .active      (ph_active)
    );

    // pin levels; a draining high phase keeps the pin up to its end unless the enable flag is cleared
    always_comb begin
        ir_next  = 1'b0;
        led_next = 1'b1;
        if (timer_output_enable_flag) begin
            led_next = !running;
            if (running && carrier_disable_bit) begin
                ir_next = 1'b1;
            end else if (ph_active) begin
                ir_next = ph_high;
            end
        end
    end

    // registered pins; indicator driven only while output is enabled
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            infrared_output_pin    <= 1'b0;
            transmit_indicator_pin <= 1'b1;
            transmit_indicator_oe  <= 1'b0;
        end else begin
            infrared_output_pin    <= ir_next;
            transmit_indicator_pin <= led_next;
            transmit_indicator_oe  <= timer_output_enable_flag;
        end
    end

    property p_load;
        @(posedge clk) disable iff (!rst_b)
        (wr_full && wr_sel == SEL_TMR) |=> count_reg == $past(wr_data[8:0]);
    endproperty
    a_load: assert property (p_load)
        else $error("timer load value not taken");

    property p_hold_zero;
        @(posedge clk) disable iff (!rst_b)
        (count_reg == 9'h000 && !(wr_any && wr_sel == SEL_TMR))
            |=> count_reg == 9'h000;
    endproperty
    a_hold_zero: assert property (p_hold_zero)
        else $error("stopped timer moved");

    property p_dec;
        @(posedge clk) disable iff (!rst_b)
        (step && running && !(wr_any && wr_sel == SEL_TMR))
            |=> count_reg == $past(count_reg) - 9'h001;
    endproperty
    a_dec: assert property (p_dec)
        else $error("timer did not decrement by one");

    property p_led;
        @(posedge clk) disable iff (!rst_b)
        timer_output_enable_flag |=> transmit_indicator_pin == !$past(running);
    endproperty
    a_led: assert property (p_led)
        else $error("indicator does not show timer state");

    property p_ir_off;
        @(posedge clk) disable iff (!rst_b)
        !timer_output_enable_flag |=> !infrared_output_pin;
    endproperty
    a_ir_off: assert property (p_ir_off)
        else $error("infrared pin high with output disabled");

    property p_ir_steady;
        @(posedge clk) disable iff (!rst_b)
        (timer_output_enable_flag && running && carrier_disable_bit)
            |=> infrared_output_pin;
    endproperty
    a_ir_steady: assert property (p_ir_steady)
        else $error("infrared pin not steady high");

    property p_low_first;
        @(posedge clk) disable iff (!rst_b)
        (load && !carrier_disable_bit && !(wr_sel == SEL_HIGH))
            |=> ##1 !infrared_output_pin;
    endproperty
    a_low_first: assert property (p_low_first)
        else $error("carrier did not start low");

    property p_tick_gap;
        @(posedge clk) disable iff (!rst_b)
        tick_reg |=> !tick_reg ##1 !tick_reg;
    endproperty
    a_tick_gap: assert property (p_tick_gap)
        else $error("carrier tick faster than twice oscillator");

    property p_low_bit9;
        @(posedge clk) disable iff (!rst_b)
        rd_sel == SEL_LOW |=> rd_data[9] == 1'b0;
    endproperty
    a_low_bit9: assert property (p_low_bit9)
        else $error("low period bit 9 read as one");
endmodule : icto_top
`default_nettype wire

// file: icto_led_model.sv
// far-side model: infrared led and transmission indicator led
// assumes the pins are registered on the rising edge of clk
`default_nettype none
module icto_led_model (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic infrared_output_pin,
    input  wire logic transmit_indicator_pin,
    input  wire logic transmit_indicator_oe,
    output var  int   pulses,
    output var  int   lit_cycles
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ir_last;

    // count light flashes of the infrared led; a passive load never
    // drives back, so nothing here can disturb the pins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ir_last <= 1'b0;
            pulses  <= 0;
        end else begin
            ir_last <= infrared_output_pin;
            if (infrared_output_pin === 1'b1 && ir_last === 1'b0) begin
                pulses <= pulses + 1;
            end
        end
    end

    // indicator led sinks current only when driven low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lit_cycles <= 0;
        end else if (transmit_indicator_oe === 1'b1
                     && transmit_indicator_pin === 1'b0) begin
            lit_cycles <= lit_cycles + 1;
        end
    end
endmodule : icto_led_model
`default_nettype wire

// file: tb_icto_top.sv
// self-checking bench for the infrared carrier timer output stage
// assumes icto_pkg, icto_top and icto_led_model are compiled first
`default_nettype none
module tb_icto_top;
    timeunit 1ns;
    timeprecision 1ps;
    import icto_pkg::*;

    logic       clk;
    logic       rst_b;
    icto_sel_t  wr_sel;
    logic       wr_full;
    logic       wr_nib;
    logic       nib_idx;
    logic [3:0] nib_data;
    logic [9:0] wr_data;
    icto_sel_t  rd_sel;
    logic [9:0] rd_data;
    logic       timer_zero;
    logic       ir;
    logic       led;
    logic       led_oe;
    int         pulses;
    int         lit_cycles;
    int         fails;
    int         samples_checked;
    int         cycles;

    icto_top dut_u (
        .clk                    (clk),
        .rst_b                  (rst_b),
        .wr_sel                 (wr_sel),
        .wr_full                (wr_full),
        .wr_nib                 (wr_nib),
        .nib_idx                (nib_idx),
        .nib_data               (nib_data),
        .wr_data                (wr_data),
        .rd_sel                 (rd_sel),
        .rd_data                (rd_data),
        .timer_zero             (timer_zero),
        .infrared_output_pin    (ir),
        .transmit_indicator_pin (led),
        .transmit_indicator_oe  (led_oe)
    );

    icto_led_model led_u (
        .clk                    (clk),
        .rst_b                  (rst_b),
        .infrared_output_pin    (ir),
        .transmit_indicator_pin (led),
        .transmit_indicator_oe  (led_oe),
        .pulses                 (pulses),
        .lit_cycles             (lit_cycles)
    );

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic end_sim;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    // the whole run needs about 1700 cycles; a hang is cut off well after
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            fails++;
            end_sim();
        end
    end

    task automatic chk_bit(string nm, logic exp, logic got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s exp %b got %b", nm, exp, got);
        end
    endtask : chk_bit

    task automatic chk_word(string nm, logic [9:0] exp, logic [9:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask : chk_word

    // durations wobble by a clk because ticks come every 3 or 4 clks
    task automatic chk_rng(string nm, int lo, int hi, int got);
        samples_checked++;
        if (got < lo || got > hi) begin
            fails++;
            $display("[ERR] %s exp %0d..%0d got %0d", nm, lo, hi, got);
        end
    endtask : chk_rng

    task automatic wr(icto_sel_t s, logic [9:0] d);
        @(negedge clk);
        wr_sel  = s;
        wr_data = d;
        wr_full = 1'b1;
        @(negedge clk);
        wr_full = 1'b0;
    endtask : wr

    task automatic nib(icto_sel_t s, logic idx, logic [3:0] d);
        @(negedge clk);
        wr_sel   = s;
        nib_idx  = idx;
        nib_data = d;
        wr_nib   = 1'b1;
        @(negedge clk);
        wr_nib   = 1'b0;
    endtask : nib

    task automatic rd(icto_sel_t s, output logic [9:0] v);
        @(negedge clk);
        rd_sel = s;
        @(negedge clk);
        v = rd_data;
    endtask : rd

    task automatic wait_ir(logic lvl, output int n);
        n = 0;
        while (ir !== lvl && n < 2000) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_ir

    task automatic wait_zero(output int n);
        n = 0;
        while (timer_zero !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_zero

    task automatic t_reset_regs;
        logic [9:0] v;
        chk_bit("ir_rst", 1'b0, ir);
        chk_bit("led_rst", 1'b1, led);
        chk_bit("zero_rst", 1'b1, timer_zero);
        rd(SEL_LOW, v);
        chk_word("low_rst", 10'h001, v);
        rd(SEL_HIGH, v);
        chk_word("high_rst", 10'h201, v);
        wr(SEL_LOW, 10'h3FF);
        rd(SEL_LOW, v);
        chk_word("low_bit9", 10'h1FF, v);
        nib(SEL_LOW, 1'b1, 4'h3);
        rd(SEL_LOW, v);
        chk_word("low_nib", 10'h13F, v);
        wr(SEL_HIGH, 10'h3FF);
        nib(SEL_HIGH, 1'b0, 4'h5);
        nib(SEL_HIGH, 1'b1, 4'hA);
        rd(SEL_HIGH, v);
        chk_word("high_nib", 10'h3A5, v);
    endtask : t_reset_regs

    // carrier disabled: steady high for one count step
    task automatic t_steady;
        int n;
        wr(SEL_LOW, 10'h001);
        wr(SEL_HIGH, 10'h201);
        wr(SEL_TMR, 10'h201);
        @(negedge clk);
        @(negedge clk);
        chk_bit("led_run", 1'b0, led);
        chk_bit("oe_run", 1'b1, led_oe);
        chk_bit("ir_steady", 1'b1, ir);
        wait_zero(n);
        chk_rng("step_len", 394, 404, n + 2);
        @(negedge clk);
        @(negedge clk);
        chk_bit("ir_stop", 1'b0, ir);
        chk_bit("led_stop", 1'b1, led);
    endtask : t_steady

    // output flag clear: count runs but pins stay idle
    task automatic t_noena;
        int l0;
        logic [9:0] v;
        l0 = lit_cycles;
        wr(SEL_TMR, 10'h005);
        repeat (3) @(negedge clk);
        chk_bit("zero_run", 1'b0, timer_zero);
        chk_bit("ir_dis", 1'b0, ir);
        chk_bit("oe_dis", 1'b0, led_oe);
        // a nibble load restarts the prescaler, so no step comes yet
        nib(SEL_TMR, 1'b0, 4'h3);
        rd(SEL_TMR, v);
        chk_word("tmr_nib", 10'h003, v);
        wr(SEL_TMR, 10'h000);
        chk_bit("zero_load", 1'b1, timer_zero);
        chk_rng("led_dark", 0, 0, lit_cycles - l0);
    endtask : t_noena

    // 20-tick phases, count 2 ends inside a low phase
    task automatic t_carrier;
        int n;
        int p0;
        wr(SEL_LOW, 10'h013);
        wr(SEL_HIGH, 10'h013);
        p0 = pulses;
        wr(SEL_TMR, 10'h202);
        wait_ir(1'b1, n);
        chk_rng("first_low", 61, 67, n + 1);
        wait_ir(1'b0, n);
        chk_rng("high_len", 61, 64, n);
        wait_zero(n);
        @(negedge clk);
        @(negedge clk);
        chk_bit("ir_cut", 1'b0, ir);
        chk_rng("pulses", 6, 6, pulses - p0);
    endtask : t_carrier

    // 120-tick high phase straddles the zero point
    task automatic t_hold;
        int n;
        wr(SEL_LOW, 10'h013);
        wr(SEL_HIGH, 10'h077);
        wr(SEL_TMR, 10'h201);
        wait_zero(n);
        @(negedge clk);
        chk_bit("ir_hold", 1'b1, ir);
        wait_ir(1'b0, n);
        chk_rng("hold_len", 32, 42, n + 1);
    endtask : t_hold

    initial begin
        rst_b    = 1'b0;
        wr_sel   = SEL_TMR;
        wr_full  = 1'b0;
        wr_nib   = 1'b0;
        nib_idx  = 1'b0;
        nib_data = 4'h0;
        wr_data  = 10'h000;
        rd_sel   = SEL_LOW;
        fails    = 0;
        samples_checked = 0;
        cycles   = 0;
        // count rising edges so a start-up edge on clk cannot shorten reset
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        t_reset_regs();
        t_steady();
        t_noena();
        t_carrier();
        t_hold();
        end_sim();
    end
endmodule : tb_icto_top
`default_nettype wire
